// ==== bench/cpc_mac_model.sv ====
module cpc_mac_model #(
    parameter DW = 8
) (
    input logic clk,
    input logic rst,
    output logic [DW-1:0] mac_txd,
    output logic mac_tx_en,
    output logic [DW-1:0] line_rxd,
    output logic line_rx_dv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // mac transmit stream and line receive stream
    // ------------------------------------------------------------
    logic [DW-1:0] cnt = '0;
    always @(posedge clk) cnt <= rst ? '0 : cnt + 1'b1;
    assign mac_tx_en = cnt[2:0] != 3'h7;
    // idle cycles carry inverted data so stale bytes never look valid
    assign mac_txd = mac_tx_en ? cnt : ~cnt;
    assign line_rxd = cnt ^ DW'(8'hA5);
    assign line_rx_dv = cnt[0];
endmodule

// ==== bench/cpc_port_control_asserts.sv ====
`include "cpc_consts.vh"
module cpc_port_control_chk #(
    parameter DW = 8,
    parameter RESET_CYCLES = 8
) (
    input logic clk,
    input logic rst,
    input logic ce,
    input logic [4:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic reg_wr,
    input logic [DW-1:0] mac_txd,
    input logic mac_tx_en,
    input logic [DW-1:0] mac_rxd,
    input logic mac_rx_dv,
    input logic mac_rx_oe,
    input logic line_tx_en,
    input logic [DW-1:0] line_txd,
    input logic [DW-1:0] line_rxd,
    input logic line_rx_dv,
    input logic port_sm_reset,
    input logic aneg_restart,
    input logic [1:0] loop_speed,
    input logic link_enable,
    input logic core_power_down,
    input logic mac_if_power_down
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // shadow of the written control and aux bits
    // ------------------------------------------------------------
    logic lb;
    logic iso;
    logic pdc;
    logic [3:0] aux;
    logic pd_q;
    wire pd = pdc | aux[0];
    always @(posedge clk) begin
        if (rst) begin
            lb <= 1'b0;
            iso <= 1'b0;
            pdc <= 1'b0;
            aux <= 4'h8;
            pd_q <= 1'b0;
        end else if (ce) begin
            pd_q <= pd;
            if (reg_wr && reg_addr == 5'h00) begin
                lb <= reg_wdata[14] & ~reg_wdata[15];
                iso <= reg_wdata[10] & ~reg_wdata[15];
                pdc <= reg_wdata[11];
            end
            if (reg_wr && reg_addr == 5'h01) begin
                aux <= reg_wdata[3:0];
            end
            // leaving power down starts a software reset
            if (pd_q && !pd) begin
                lb <= 1'b0;
                iso <= 1'b0;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_swrst_start: assert property (
        ce && reg_wr && reg_addr == 5'h00 && reg_wdata[15] |=> port_sm_reset)
        else $error("sw reset did not start");
    a_swrst_len: assert property (
        $rose(port_sm_reset) |-> port_sm_reset[*8] ##[0:1] !port_sm_reset)
        else $error("sw reset length wrong");
    a_restart_after: assert property (
        $fell(port_sm_reset) && !pd |-> ##[0:2] aneg_restart)
        else $error("no restart after reset");
    a_restart_pulse: assert property (
        aneg_restart |=> !aneg_restart)
        else $error("restart pulse too long");
    a_loop_echo: assert property (
        $past(lb) && lb && !port_sm_reset && !$past(iso) && !$past(mac_if_power_down)
        |-> mac_rxd == ($past(mac_tx_en) ? $past(mac_txd) : '0)
            && mac_rx_dv == $past(mac_tx_en) && !line_tx_en && line_txd == '0)
        else $error("loopback data not returned");
    a_loop_link: assert property (
        $past(lb) && lb && $stable(aux) |-> !link_enable && loop_speed == aux[3:2])
        else $error("loopback link or speed wrong");
    a_iso_quiet: assert property (
        $past(iso) && iso && !port_sm_reset |-> !mac_rx_oe && !mac_rx_dv && mac_rxd == '0)
        else $error("isolate still drives receive");
    a_pd_level: assert property (
        $past(pd) && pd |-> core_power_down)
        else $error("power down not entered");
    a_pd_macif: assert property (
        $past(pd) && pd && $stable(aux) |-> mac_if_power_down == !aux[1])
        else $error("mac interface power wrong");
    a_pd_exit: assert property (
        $fell(pd) |-> ##[0:2] port_sm_reset)
        else $error("no reset on power-down exit");
    a_tx_pass: assert property (
        $past(ce) && !$past(rst) && !$past(lb) && !$past(iso) && !$past(mac_if_power_down)
        |-> line_tx_en == $past(mac_tx_en)
            && line_txd == ($past(mac_tx_en) ? $past(mac_txd) : '0))
        else $error("transmit path not passed through");
    a_rx_pass: assert property (
        $past(ce) && !$past(rst) && !$past(lb) && !$past(iso) && !$past(mac_if_power_down)
        |-> mac_rx_oe && mac_rx_dv == $past(line_rx_dv) && mac_rxd == $past(line_rxd))
        else $error("receive path not passed through");
    cover property ($rose(port_sm_reset));
    cover property ($past(lb) && lb);
    cover property ($fell(pd));
endmodule
bind cpc_port_control cpc_port_control_chk #(.DW(DW), .RESET_CYCLES(RESET_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .mac_rxd(mac_rxd),
    .mac_rx_dv(mac_rx_dv), .mac_rx_oe(mac_rx_oe), .line_tx_en(line_tx_en),
    .line_txd(line_txd), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
    .port_sm_reset(port_sm_reset), .aneg_restart(aneg_restart), .loop_speed(loop_speed),
    .link_enable(link_enable), .core_power_down(core_power_down),
    .mac_if_power_down(mac_if_power_down));

// ==== bench/tb_cpc_port_control.sv ====
module tb_cpc_port_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [15:0] reg_rdata;
    wire [7:0] mac_txd, line_rxd, mac_rxd, line_txd;
    wire mac_tx_en, line_rx_dv, mac_rx_dv, mac_rx_oe, line_tx_en, port_sm_reset, aneg_restart;
    wire aneg_run, adv_1000_only, adv_1000_full, adv_1000_half, duplex_active, link_enable;
    wire core_power_down, mac_if_power_down;
    wire [1:0] speed_active, loop_speed;
    int err_total = 0;
    int checks_done = 0;
    int n;
    // ------------------------------------------------------------
    // rows: write flag, address, write data or expected read data
    // ------------------------------------------------------------
    localparam logic [21:0] ROWS [18] = '{22'h200100, 22'h000100, 22'h02001E, 22'h200300,
        22'h020008, 22'h202340, 22'h02000B, 22'h200340, 22'h02009A, 22'h200240, 22'h020092,
        22'h1F0000, 22'h3FFFFF, 22'h000040, 22'h21000C, 22'h01000C, 22'h201340, 22'h02001E};
    always #12.5 clk = ~clk;
    cpc_port_control #(.DW(8), .RESET_CYCLES(8)) u_dut (.clk(clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .line_rxd(line_rxd),
        .line_rx_dv(line_rx_dv), .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv),
        .mac_rx_oe(mac_rx_oe), .line_txd(line_txd), .line_tx_en(line_tx_en),
        .port_sm_reset(port_sm_reset), .aneg_restart(aneg_restart), .aneg_run(aneg_run),
        .adv_1000_only(adv_1000_only), .adv_1000_full(adv_1000_full),
        .adv_1000_half(adv_1000_half), .speed_active(speed_active),
        .duplex_active(duplex_active), .loop_speed(loop_speed), .link_enable(link_enable),
        .core_power_down(core_power_down), .mac_if_power_down(mac_if_power_down));
    cpc_mac_model #(.DW(8)) u_mac (.clk(clk), .rst(rst), .mac_txd(mac_txd),
        .mac_tx_en(mac_tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv));
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask
    // sel 0 waits on the reset level, sel 1 on the restart pulse
    task automatic wait_sig(input bit sel, input logic lvl);
        #1;
        n = 0;
        while ((sel ? aneg_restart : port_sm_reset) !== lvl && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0, sel ? aneg_restart : port_sm_reset}, {15'h0, lvl});
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            if (ROWS[i][21]) wr(ROWS[i][20:16], ROWS[i][15:0]);
            else rdc(ROWS[i][20:16], ROWS[i][15:0]);
        end
        chk({11'h0, aneg_run, duplex_active, speed_active, adv_1000_only}, 16'h001C);
        wr(5'h00, 16'h5140);
        repeat (3) @(negedge clk);
        chk({13'h0, line_tx_en, link_enable, loop_speed}, 16'h0003);
        wr(5'h00, 16'h9140);
        @(negedge clk);
        chk({15'h0, port_sm_reset}, 16'h0001);
        rdc(5'h00, 16'h9140);
        wait_sig(1'b0, 1'b0);
        wait_sig(1'b1, 1'b1);
        rdc(5'h00, 16'h1140);
        chk({15'h0, link_enable}, 16'h0001);
        wr(5'h00, 16'h1540);
        repeat (2) @(negedge clk);
        chk({14'h0, mac_rx_oe, mac_rx_dv}, 16'h0000);
        wr(5'h00, 16'h1140);
        repeat (2) @(negedge clk);
        chk({15'h0, mac_rx_oe}, 16'h0001);
        wr(5'h01, 16'h0001);
        repeat (2) @(negedge clk);
        chk({14'h0, core_power_down, mac_if_power_down}, 16'h0003);
        wr(5'h00, 16'h0940);
        wr(5'h01, 16'h0002);
        repeat (2) @(negedge clk);
        chk({14'h0, core_power_down, mac_if_power_down}, 16'h0002);
        wr(5'h00, 16'h0140);
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        wait_sig(1'b1, 1'b1);
        rdc(5'h02, 16'h009A);
        chk({13'h0, adv_1000_only, adv_1000_full, adv_1000_half}, 16'h0006);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(5'h00, 16'h1140);
        rdc(5'h01, 16'h0008);
        rdc(5'h02, 16'h001E);
        // a write while the clock enable is low must be lost
        ce <= 1'b0;
        wr(5'h00, 16'h4000);
        ce <= 1'b1;
        rdc(5'h00, 16'h1140);
        give_verdict();
    end
endmodule

// ==== design/cpc_loop_mux.v ====
// mac-facing data path: loopback turn-around and isolation
module cpc_loop_mux #(
    parameter DW = 8
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire loop_on,
    input wire isolate_on,
    input wire mac_off,
    input wire [DW-1:0] mac_txd,
    input wire mac_tx_en,
    input wire [DW-1:0] line_rxd,
    input wire line_rx_dv,
    output reg [DW-1:0] mac_rxd,
    output reg mac_rx_dv,
    output reg mac_rx_oe,
    output reg [DW-1:0] line_txd,
    output reg line_tx_en
);
    wire tx_ok;

    assign tx_ok = mac_tx_en & ~isolate_on & ~mac_off;

    always @(posedge clk) begin
        if (rst) begin
            mac_rxd <= {DW{1'b0}};
            mac_rx_dv <= 1'b0;
            mac_rx_oe <= 1'b0;
            line_txd <= {DW{1'b0}};
            line_tx_en <= 1'b0;
        end else if (ce) begin
            mac_rx_oe <= ~isolate_on & ~mac_off;
            if (loop_on) begin
                mac_rxd <= tx_ok ? mac_txd : {DW{1'b0}};
                mac_rx_dv <= tx_ok;
                line_txd <= {DW{1'b0}};
                line_tx_en <= 1'b0;
            end else begin
                mac_rxd <= (isolate_on | mac_off) ? {DW{1'b0}} : line_rxd;
                mac_rx_dv <= line_rx_dv & ~isolate_on & ~mac_off;
                line_txd <= tx_ok ? mac_txd : {DW{1'b0}};
                line_tx_en <= tx_ok;
            end
        end
    end
endmodule

// ==== design/cpc_port_control.v ====
// Decided for this implementation: the strobed register port.
`include "cpc_consts.vh"

module cpc_port_control #(
    parameter DW = 8,
    parameter RESET_CYCLES = `CPC_SW_RESET_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [`CPC_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [DW-1:0] mac_txd,
    input wire mac_tx_en,
    input wire [DW-1:0] line_rxd,
    input wire line_rx_dv,
    output wire [DW-1:0] mac_rxd,
    output wire mac_rx_dv,
    output wire mac_rx_oe,
    output wire [DW-1:0] line_txd,
    output wire line_tx_en,
    output wire port_sm_reset,
    output reg aneg_restart,
    output reg aneg_run,
    output reg adv_1000_only,
    output reg adv_1000_full,
    output reg adv_1000_half,
    output reg [1:0] speed_active,
    output reg duplex_active,
    output reg [1:0] loop_speed,
    output reg link_enable,
    output reg core_power_down,
    output reg mac_if_power_down
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg loop_bit;
    reg isolate_bit;
    reg pdown_bit;
    reg restart_bit;
    reg [1:0] speed_pend;
    reg aneg_pend;
    reg duplex_pend;
    reg pdown2_bit;
    reg keep_mac_bit;
    reg [1:0] lb_speed;
    reg aneg_active;
    reg pd_prev;
    reg restart_req;

    wire wr_ctl;
    wire wr_aux;
    wire pd_now;
    wire pd_exit;
    wire sw_start;
    wire apply;
    wire rst_busy;
    wire rst_done;
    wire forced_gig;
    reg [1:0] next_speed;
    reg next_aneg;
    reg next_duplex;

    assign wr_ctl = reg_wr & (reg_addr == `CPC_OFS_CONTROL);
    assign wr_aux = reg_wr & (reg_addr == `CPC_OFS_AUX);

    // ------------------------------------------------------------
    // power down and apply events
    // ------------------------------------------------------------
    // either bit holds the port down; both must be clear to leave
    assign pd_now = pdown_bit | pdown2_bit;
    assign pd_exit = pd_prev & ~pd_now;
    assign sw_start = (wr_ctl & reg_wdata[`CPC_BIT_RESET]) | pd_exit;
    assign apply = sw_start | (wr_ctl & reg_wdata[`CPC_BIT_RESTART]);
    assign port_sm_reset = rst_busy;

    // pending values after this cycle's write, used when applied
    always @* begin
        next_speed = speed_pend;
        next_aneg = aneg_pend;
        next_duplex = duplex_pend;
        if (wr_ctl) begin
            next_speed = {reg_wdata[`CPC_BIT_SPD_MSB], reg_wdata[`CPC_BIT_SPD_LSB]};
            next_aneg = reg_wdata[`CPC_BIT_ANEG];
            next_duplex = reg_wdata[`CPC_BIT_DUPLEX];
        end
    end

    // ------------------------------------------------------------
    // software reset sequencer
    // ------------------------------------------------------------
    cpc_reset_seq #(
        .CYCLES(RESET_CYCLES),
        .CW(16)
    ) u_reset_seq (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(sw_start),
        .busy(rst_busy),
        .done(rst_done)
    );

    // ------------------------------------------------------------
    // control and aux registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            loop_bit <= 1'b0;
            isolate_bit <= 1'b0;
            pdown_bit <= 1'b0;
            speed_pend <= `CPC_RST_SPD;
            aneg_pend <= `CPC_RST_ANEG;
            duplex_pend <= `CPC_RST_DUPLEX;
            pdown2_bit <= 1'b0;
            keep_mac_bit <= 1'b0;
            lb_speed <= `CPC_RST_LB_SPD;
            pd_prev <= 1'b0;
        end else if (ce) begin
            pd_prev <= pd_now;
            speed_pend <= next_speed;
            aneg_pend <= next_aneg;
            duplex_pend <= next_duplex;
            if (wr_ctl) begin
                loop_bit <= reg_wdata[`CPC_BIT_LOOP];
                isolate_bit <= reg_wdata[`CPC_BIT_ISOLATE];
                pdown_bit <= reg_wdata[`CPC_BIT_PDOWN];
            end
            if (wr_aux) begin
                pdown2_bit <= reg_wdata[`CPC_BIT_PDOWN2];
                keep_mac_bit <= reg_wdata[`CPC_BIT_KEEP_MAC];
                lb_speed <= {reg_wdata[`CPC_BIT_LB_SPD_MSB], reg_wdata[`CPC_BIT_LB_SPD_LSB]};
            end
            // software reset clears loopback and isolate, power down is kept
            if (sw_start) begin
                loop_bit <= 1'b0;
                isolate_bit <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // active settings, taken over only on an apply event
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            speed_active <= `CPC_RST_SPD;
            aneg_active <= `CPC_RST_ANEG;
            duplex_active <= `CPC_RST_DUPLEX;
        end else if (ce) begin
            if (apply) begin
                speed_active <= next_speed;
                aneg_active <= next_aneg;
                duplex_active <= next_duplex;
            end
        end
    end

    // ------------------------------------------------------------
    // negotiation restart
    // ------------------------------------------------------------
    // the request stays pending while the port is in reset or power
    // down; a new request in the clearing cycle is kept
    always @(posedge clk) begin
        if (rst) begin
            restart_bit <= 1'b0;
            restart_req <= 1'b1;
            aneg_restart <= 1'b0;
        end else if (ce) begin
            aneg_restart <= 1'b0;
            // a set on rst_done is served by the pulse below in the same cycle, so no second pulse
            if (sw_start | rst_done) begin
                restart_req <= 1'b1;
            end
            if (restart_req & ~rst_busy & ~pd_now & ~sw_start) begin
                aneg_restart <= 1'b1;
                restart_req <= 1'b0;
                restart_bit <= 1'b0;
            end
            if (wr_ctl & reg_wdata[`CPC_BIT_RESTART]) begin
                restart_bit <= 1'b1;
                restart_req <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // port-level outputs
    // ------------------------------------------------------------
    assign forced_gig = ~aneg_active & (speed_active == `CPC_SPD_1000);

    always @(posedge clk) begin
        if (rst) begin
            aneg_run <= 1'b0;
            adv_1000_only <= 1'b0;
            adv_1000_full <= 1'b0;
            adv_1000_half <= 1'b0;
            loop_speed <= `CPC_RST_LB_SPD;
            link_enable <= 1'b0;
            core_power_down <= 1'b0;
            mac_if_power_down <= 1'b0;
        end else if (ce) begin
            aneg_run <= (aneg_active | forced_gig) & ~pd_now & ~rst_busy;
            adv_1000_only <= forced_gig;
            adv_1000_full <= forced_gig & duplex_active;
            adv_1000_half <= forced_gig & ~duplex_active;
            loop_speed <= loop_bit ? lb_speed : speed_active;
            link_enable <= ~loop_bit & ~pd_now & ~rst_busy;
            core_power_down <= pd_now;
            mac_if_power_down <= pd_now & ~keep_mac_bit;
        end
    end

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    cpc_loop_mux #(
        .DW(DW)
    ) u_loop_mux (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .loop_on(loop_bit),
        .isolate_on(isolate_bit),
        .mac_off(mac_if_power_down),
        .mac_txd(mac_txd),
        .mac_tx_en(mac_tx_en),
        .line_rxd(line_rxd),
        .line_rx_dv(line_rx_dv),
        .mac_rxd(mac_rxd),
        .mac_rx_dv(mac_rx_dv),
        .mac_rx_oe(mac_rx_oe),
        .line_txd(line_txd),
        .line_tx_en(line_tx_en)
    );

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `CPC_OFS_CONTROL: begin
                        reg_rdata[`CPC_BIT_RESET] <= rst_busy;
                        reg_rdata[`CPC_BIT_LOOP] <= loop_bit;
                        reg_rdata[`CPC_BIT_SPD_LSB] <= speed_pend[0];
                        reg_rdata[`CPC_BIT_ANEG] <= aneg_pend;
                        reg_rdata[`CPC_BIT_PDOWN] <= pdown_bit;
                        reg_rdata[`CPC_BIT_ISOLATE] <= isolate_bit;
                        reg_rdata[`CPC_BIT_RESTART] <= restart_bit;
                        reg_rdata[`CPC_BIT_DUPLEX] <= duplex_pend;
                        reg_rdata[`CPC_BIT_SPD_MSB] <= speed_pend[1];
                    end
                    `CPC_OFS_AUX: begin
                        reg_rdata[`CPC_BIT_PDOWN2] <= pdown2_bit;
                        reg_rdata[`CPC_BIT_KEEP_MAC] <= keep_mac_bit;
                        reg_rdata[`CPC_BIT_LB_SPD_LSB] <= lb_speed[0];
                        reg_rdata[`CPC_BIT_LB_SPD_MSB] <= lb_speed[1];
                    end
                    `CPC_OFS_STATUS: begin
                        reg_rdata[`CPC_BIT_ST_SPD_LSB] <= speed_active[0];
                        reg_rdata[`CPC_BIT_ST_SPD_MSB] <= speed_active[1];
                        reg_rdata[`CPC_BIT_ST_ANEG] <= aneg_active;
                        reg_rdata[`CPC_BIT_ST_DUPLEX] <= duplex_active;
                        reg_rdata[`CPC_BIT_ST_RUN] <= aneg_run;
                        reg_rdata[`CPC_BIT_ST_PDOWN] <= pd_now;
                        reg_rdata[`CPC_BIT_ST_BUSY] <= rst_busy;
                        reg_rdata[`CPC_BIT_ST_FORCED] <= forced_gig;
                    end
                    default: begin
                        reg_rdata <= 16'h0000;
                    end
                endcase
            end
        end
    end
endmodule

// ==== design/cpc_reset_seq.v ====
`include "cpc_consts.vh"

// holds the port machines in reset for a fixed count after start
module cpc_reset_seq #(
    parameter CYCLES = `CPC_SW_RESET_CYCLES,
    parameter CW = 8
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire start,
    output reg busy,
    output reg done
);
    reg [CW-1:0] count;

    always @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            count <= {CW{1'b0}};
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                count <= CYCLES[CW-1:0] - 1'b1;
            end else if (busy) begin
                if (count == {CW{1'b0}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule

// ==== shared/cpc_consts.vh ====
`ifndef CPC_CONSTS_VH
`define CPC_CONSTS_VH
// Operation
// - reset bit resets port machines, then self-clears
// - loopback returns mac transmit data to receive
// - loopback drops link, uses mac-side speed
// - speed pair msb/lsb: 10 gig, 00 ten
// - speed and aneg writes wait for apply event
// - forced gigabit still negotiates, single advert
// - aneg enable bit, hardware reset value one
// - power down is or of two bits
// - power-down exit does reset and restart
// - power down keeps mac interface if asked
// - restart self-clears, also follows every reset
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CPC_ADDR_W 5
`define CPC_OFS_CONTROL 5'h00
`define CPC_OFS_AUX 5'h01
`define CPC_OFS_STATUS 5'h02
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CPC_BIT_RESET 15
`define CPC_BIT_LOOP 14
`define CPC_BIT_SPD_LSB 13
`define CPC_BIT_ANEG 12
`define CPC_BIT_PDOWN 11
`define CPC_BIT_ISOLATE 10
`define CPC_BIT_RESTART 9
`define CPC_BIT_DUPLEX 8
`define CPC_BIT_SPD_MSB 6
// ------------------------------------------------------------
// aux register fields
// ------------------------------------------------------------
`define CPC_BIT_PDOWN2 0
`define CPC_BIT_KEEP_MAC 1
`define CPC_BIT_LB_SPD_LSB 2
`define CPC_BIT_LB_SPD_MSB 3
// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define CPC_BIT_ST_SPD_LSB 0
`define CPC_BIT_ST_SPD_MSB 1
`define CPC_BIT_ST_ANEG 2
`define CPC_BIT_ST_DUPLEX 3
`define CPC_BIT_ST_RUN 4
`define CPC_BIT_ST_PDOWN 5
`define CPC_BIT_ST_BUSY 6
`define CPC_BIT_ST_FORCED 7
// ------------------------------------------------------------
// reset values and encodings
// ------------------------------------------------------------
`define CPC_RST_SPD 2'h2
`define CPC_RST_ANEG 1'h1
`define CPC_RST_DUPLEX 1'h1
`define CPC_RST_LB_SPD 2'h2
`define CPC_SPD_1000 2'h2
`define CPC_SPD_10 2'h0
`define CPC_SPD_RSVD 2'h3
`define CPC_SW_RESET_CYCLES 8
`endif
